/* design/srrs_top.sv */
// Speed reference selection, limiting and ramp shaping for a motor drive.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
module srrs_top import srrs_pkg::*; #(
	parameter int N_CONTACTS = 10,
	parameter int TICK_CYCLES = RAMP_TICK_CYCLES
) (
	input logic sys_clk,
	input logic rst_b,
	input logic [N_CONTACTS-1:0] contact_in,
	input logic run_fwd_in,
	input logic run_rev_in,
	input logic op_jog_key_in,
	input logic [15:0] analog_input_first,
	input logic [15:0] analog_input_second,
	input logic [15:0] analog_input_third,
	input logic [5:0] reg_addr,
	input logic [15:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [15:0] reg_rdata_q,
	output logic [15:0] out_freq_q,
	output logic running_q,
	output logic reverse_q,
	output logic remote_indicator_q
);
	localparam int NP = N_CONTACTS + 3;
	localparam int P_FWD = N_CONTACTS;
	localparam int P_REV = N_CONTACTS + 1;
	localparam int P_KEY = N_CONTACTS + 2;

	// The code space only serves one to ten contact inputs.
	if (N_CONTACTS < 1 || N_CONTACTS > 10) begin : g_chk
		$error("N_CONTACTS must lie between 1 and 10.");
	end
	if (TICK_CYCLES < 2) begin : g_chk_tick
		$error("TICK_CYCLES must be at least 2.");
	end

	logic [15:0] regs_q [0:REG_COUNT-1];
	logic [NP-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [15:0] target_q;
	logic local_mode, ref_src, full_acc, unit_sel;
	logic jog_pin, jog_sel, run_req, rev_req, master;
	logic [3:0] step_raw, step_idx;
	logic [1:0] pair;
	logic [5:0] acc_addr, dec_addr;
	logic [15:0] preset_val, ref_val, fmax, fmin;
	logic [15:0] upper_val, lower_val, mlower_val, low_eff;
	logic [15:0] lim_lo, lim, target_d;
	logic [15:0] flags, rd_val;
	logic reverse_d, running_d, wr_ok;

	// Contact function lookup over all contact inputs.
	function automatic logic fn_on(input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N_CONTACTS; i++) begin
			if (regs_q[int'(ADDR_FCODE0) + i][7:0] == code && pin_q[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// Percent of maximum frequency, in 0.1 % steps.
	function automatic logic [15:0] pct_of(input logic [15:0] p);
		logic [31:0] prod;
		prod = 32'(p) * 32'(fmax) / 32'(PCT_FULL);
		return prod[15:0];
	endfunction

	// Ramp time in 0.01 s ticks, scaled when 0.1 s units are chosen.
	function automatic logic [19:0] ticks_of(input logic [15:0] v);
		return unit_sel ? 20'(v) * 20'(UNIT_SCALE) : 20'(v);
	endfunction

	// S-curve time held to its 2.5 s ceiling.
	function automatic logic [7:0] scurve_of(input logic [15:0] v);
		return (v > 16'(SCURVE_MAX)) ? SCURVE_MAX : v[7:0];
	endfunction

	// Presets five to sixteen hide in reduced access mode.
	function automatic logic reg_open(input logic [5:0] a);
		logic hidden;
		hidden = !full_acc && a >= 6'(REDUCED_SPEEDS) && a < ADDR_JOG;
		return (int'(a) < REG_COUNT) && !hidden;
	endfunction

	// Pins settle through three flops; a change counts once two agree.
	assign pin_raw = {op_jog_key_in, run_rev_in, run_fwd_in, contact_in};
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
		end
	end

	// Control fields.
	assign local_mode = regs_q[ADDR_CTRL][CTRL_LOCAL];
	assign ref_src = regs_q[ADDR_CTRL][CTRL_REF_SRC];
	assign full_acc = regs_q[ADDR_CTRL][CTRL_FULL];
	assign unit_sel = regs_q[ADDR_CTRL][CTRL_UNIT];
	assign fmax = regs_q[ADDR_FMAX];
	assign fmin = regs_q[ADDR_FMIN];

	// Jog select: contact with code 6, or the panel key when local.
	// The jog level is sampled each cycle, so it need not lead the run.
	assign jog_pin = fn_on(FC_JOG);
	assign jog_sel = local_mode ? pin_q[P_KEY] : jog_pin;
	assign run_req = local_mode ? pin_q[P_KEY] : pin_q[P_FWD] | pin_q[P_REV];
	assign rev_req = !local_mode && pin_q[P_REV] && !pin_q[P_FWD];

	// Multi-step selects form a binary index, select one lowest.
	assign step_raw = {fn_on(FC_STEP4), fn_on(FC_STEP3), fn_on(FC_STEP2),
		fn_on(FC_STEP1)};
	assign step_idx = local_mode ? 4'h0 : step_raw;

	// Preset source per index: analog inputs may stand in.
	assign preset_val = (step_idx == 4'h0) ?
		(ref_src ? analog_input_first : regs_q[ADDR_SPEED0]) :
		(step_idx == 4'h1) ?
		((regs_q[ADDR_A3_CODE][7:0] == A3_CODE_ANALOG) ?
		analog_input_third : regs_q[ADDR_SPEED0 + 6'h01]) :
		(step_idx == 4'h2) ?
		((regs_q[ADDR_A2_CODE][7:0] == A2_CODE_ANALOG) ?
		analog_input_second : regs_q[ADDR_SPEED0 + 6'h02]) :
		regs_q[ADDR_SPEED0 + 6'(step_idx)];

	// Jog wins over any multi-step index.
	assign ref_val = jog_sel ? regs_q[ADDR_JOG] : preset_val;
	assign master = !jog_sel && step_idx == 4'h0;

	// Ramp time pair from the two time selects.
	assign pair = {fn_on(FC_TSEL2), fn_on(FC_TSEL1)};
	assign acc_addr = ADDR_TIME0 + {3'b000, pair, 1'b0};
	assign dec_addr = acc_addr + 6'h01;

	// Limits: master lower limit only on the master reference.
	assign upper_val = pct_of(regs_q[ADDR_UPPER]);
	assign lower_val = pct_of(regs_q[ADDR_LOWER]);
	assign mlower_val = pct_of(regs_q[ADDR_MLOWER]);
	assign low_eff = (master && mlower_val > lower_val) ? mlower_val :
		lower_val;
	assign lim_lo = (ref_val < low_eff) ? low_eff : ref_val;
	assign lim = (lim_lo > upper_val) ? upper_val : lim_lo;

	// No run below minimum frequency; a reversal first ramps to zero.
	assign target_d = (!run_req || lim < fmin || rev_req != reverse_q) ?
		16'h0000 : lim;
	assign reverse_d = (run_req && out_freq_q == 16'h0000) ? rev_req :
		reverse_q;
	assign running_d = target_d != 16'h0000 || out_freq_q != 16'h0000;

	// Reference and status flops.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			target_q <= 16'h0000;
			reverse_q <= 1'b0;
			running_q <= 1'b0;
			remote_indicator_q <= 1'b0;
		end else begin
			target_q <= target_d;
			reverse_q <= reverse_d;
			running_q <= running_d;
			remote_indicator_q <= !local_mode;
		end
	end

	// Ramp tick every 0.01 s; ramp times and S-curves count in ticks.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_cnt_q == 32'(TICK_CYCLES - 1);
			tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ?
				32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
		end
	end

	// Times and S-curves feed the shaper.
	srrs_ramp u_ramp (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick(tick_q),
		.target(target_q),
		.fmax(fmax),
		.t_acc(ticks_of(regs_q[acc_addr])),
		.t_dec(ticks_of(regs_q[dec_addr])),
		.s_as(scurve_of(regs_q[ADDR_SCURVE0])),
		.s_ae(scurve_of(regs_q[ADDR_SCURVE0 + 6'h01])),
		.s_ds(scurve_of(regs_q[ADDR_SCURVE0 + 6'h02])),
		.s_de(scurve_of(regs_q[ADDR_SCURVE0 + 6'h03])),
		.freq_q(out_freq_q)
	);

	// Writes land only on visible registers.
	assign wr_ok = reg_wr && reg_open(reg_addr);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_q[i] <= reg_default(i);
			end
		end else if (wr_ok) begin
			regs_q[reg_addr] <= reg_wdata;
		end
	end

	// Read mux; hidden and unmapped addresses read zero.
	assign flags = {7'h00, running_q, reverse_q, jog_sel, pair, step_idx};
	assign rd_val = (reg_addr == ADDR_STAT_FREQ) ? out_freq_q :
		(reg_addr == ADDR_STAT_FLAGS) ? flags :
		reg_open(reg_addr) ? regs_q[reg_addr] : 16'h0000;

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_q <= 16'h0000;
		end else begin
			reg_rdata_q <= reg_rd ? rd_val : 16'h0000;
		end
	end

	// Checks on the selection, limits, ramp slew and register port.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_rd_hidden;
		reg_rd && !full_acc && reg_addr >= 6'(REDUCED_SPEEDS) &&
			reg_addr < ADDR_JOG;
	endsequence
	sequence s_stopped;
		!run_req [*2];
	endsequence
	sequence s_wr_hidden;
		reg_wr && !full_acc && reg_addr >= 6'(REDUCED_SPEEDS) &&
			reg_addr < ADDR_JOG;
	endsequence
	sequence s_jog_run;
		!local_mode && jog_pin && run_req && rev_req == reverse_q;
	endsequence

	property p_jog_wins;
		jog_sel && step_idx != 4'h0 |-> ref_val == regs_q[ADDR_JOG];
	endproperty
	a_jog_wins: assert property (p_jog_wins)
		else $error("Jog did not override the step index.");

	property p_local_key;
		local_mode && pin_q[P_KEY] |-> jog_sel && run_req;
	endproperty
	a_local_key: assert property (p_local_key)
		else $error("Panel jog key did not start jogging.");

	property p_pair_four;
		fn_on(FC_TSEL1) && fn_on(FC_TSEL2) |-> acc_addr == 6'h26;
	endproperty
	a_pair_four: assert property (p_pair_four)
		else $error("Both selects closed did not pick pair four.");

	property p_upper;
		target_q != 16'h0000 |-> target_q <= $past(upper_val);
	endproperty
	a_upper: assert property (p_upper)
		else $error("Target above the upper limit.");

	property p_min_run;
		target_q != 16'h0000 |-> target_q >= $past(fmin);
	endproperty
	a_min_run: assert property (p_min_run)
		else $error("Target below the minimum frequency.");

	property p_hidden_read;
		s_rd_hidden |=> reg_rdata_q == 16'h0000;
	endproperty
	a_hidden_read: assert property (p_hidden_read)
		else $error("Hidden preset readable in reduced access.");

	property p_stop;
		s_stopped |=> target_q == 16'h0000 && !$past(running_d, 1) ||
			target_q == 16'h0000;
	endproperty
	a_stop: assert property (p_stop)
		else $error("Target not zero without a run command.");

	property p_slew;
		((target_q > out_freq_q) ? regs_q[acc_addr] != 16'h0000 :
			regs_q[dec_addr] != 16'h0000) &&
			$stable(acc_addr) |=> out_freq_q == $past(out_freq_q) ||
			out_freq_q == $past(out_freq_q) + 16'h0001 ||
			out_freq_q == $past(out_freq_q) - 16'h0001;
	endproperty
	a_slew: assert property (p_slew)
		else $error("Output moved more than one unit per cycle.");

	property p_master_low;
		jog_sel |-> low_eff == lower_val;
	endproperty
	a_master_low: assert property (p_master_low)
		else $error("Master lower limit applied to jog.");

	property p_jog_run;
		s_jog_run ##0 (regs_q[ADDR_JOG] >= fmin &&
			regs_q[ADDR_JOG] >= lower_val && regs_q[ADDR_JOG] <= upper_val)
			|=> target_q == $past(regs_q[ADDR_JOG]);
	endproperty
	a_jog_run: assert property (p_jog_run)
		else $error("Jog run missed the jog speed.");

	property p_step_index;
		!jog_sel && step_idx == 4'h5 |->
			ref_val == regs_q[ADDR_SPEED0 + 6'h05];
	endproperty
	a_step_index: assert property (p_step_index)
		else $error("Step index five did not pick preset six.");

	property p_low_all;
		lower_val <= upper_val |-> lim >= lower_val;
	endproperty
	a_low_all: assert property (p_low_all)
		else $error("Reference below the general lower limit.");

	property p_low_master;
		master && mlower_val <= upper_val |-> lim >= mlower_val;
	endproperty
	a_low_master: assert property (p_low_master)
		else $error("Master reference below its lower limit.");

	property p_hidden_write;
		s_wr_hidden |=> regs_q[$past(reg_addr)] == $past(regs_q[reg_addr]);
	endproperty
	a_hidden_write: assert property (p_hidden_write)
		else $error("Hidden preset written in reduced access.");

	property p_key_release;
		local_mode && !pin_q[P_KEY] |=> target_q == 16'h0000;
	endproperty
	a_key_release: assert property (p_key_release)
		else $error("Released panel jog key did not stop the jog.");

	property p_analog_one;
		!jog_sel && step_idx == 4'h0 && ref_src |->
			ref_val == analog_input_first;
	endproperty
	a_analog_one: assert property (p_analog_one)
		else $error("Preset one ignored the first analog input.");
endmodule

/* design/srrs_pkg.sv */
// Constants, register map and reset values for the speed reference ramp.
package srrs_pkg;
	localparam int DW = 16;
	localparam int AW = 6;
	localparam int REG_COUNT = 49;
	localparam logic [5:0] ADDR_SPEED0 = 6'h00;
	localparam logic [5:0] ADDR_JOG = 6'h10;
	localparam logic [5:0] ADDR_FCODE0 = 6'h11;
	localparam logic [5:0] ADDR_CTRL = 6'h1B;
	localparam logic [5:0] ADDR_A3_CODE = 6'h1C;
	localparam logic [5:0] ADDR_A2_CODE = 6'h1D;
	localparam logic [5:0] ADDR_TIME0 = 6'h20;
	localparam logic [5:0] ADDR_SCURVE0 = 6'h28;
	localparam logic [5:0] ADDR_UPPER = 6'h2C;
	localparam logic [5:0] ADDR_LOWER = 6'h2D;
	localparam logic [5:0] ADDR_MLOWER = 6'h2E;
	localparam logic [5:0] ADDR_FMAX = 6'h2F;
	localparam logic [5:0] ADDR_FMIN = 6'h30;
	localparam logic [5:0] ADDR_STAT_FREQ = 6'h31;
	localparam logic [5:0] ADDR_STAT_FLAGS = 6'h32;
	localparam int REDUCED_SPEEDS = 4;
	// Control register bit positions.
	localparam int CTRL_REF_SRC = 0;
	localparam int CTRL_FULL = 1;
	localparam int CTRL_UNIT = 2;
	localparam int CTRL_LOCAL = 3;
	// Contact input and analog input function codes.
	localparam logic [7:0] FC_STEP1 = 8'h03;
	localparam logic [7:0] FC_STEP2 = 8'h04;
	localparam logic [7:0] FC_STEP3 = 8'h05;
	localparam logic [7:0] FC_JOG = 8'h06;
	localparam logic [7:0] FC_TSEL1 = 8'h07;
	localparam logic [7:0] FC_TSEL2 = 8'h1A;
	localparam logic [7:0] FC_STEP4 = 8'h20;
	localparam logic [7:0] A3_CODE_ANALOG = 8'h02;
	localparam logic [7:0] A2_CODE_ANALOG = 8'h03;
	// Values after reset.
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_JOG = 16'h0258;
	localparam logic [15:0] RST_CTRL = 16'h0006;
	localparam logic [15:0] RST_A3_CODE = 16'h001F;
	localparam logic [15:0] RST_TIME = 16'h0064;
	localparam logic [15:0] RST_SCURVE = 16'h0014;
	localparam logic [15:0] RST_UPPER = 16'h03E8;
	localparam logic [15:0] RST_FMAX = 16'h1770;
	localparam logic [15:0] RST_FMIN = 16'h0096;
	localparam logic [7:0] SCURVE_MAX = 8'hFA;
	localparam int PCT_FULL = 1000;
	localparam int UNIT_SCALE = 10;
	// Ramp tick of 0.01 s at the 250 MHz system clock.
	localparam int CLK_MHZ = 250;
	localparam int RAMP_TICK_US = 10000;
	localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * CLK_MHZ;

	// Reset value of each stored register by index.
	function automatic logic [15:0] reg_default(input int idx);
		logic [15:0] v;
		v = RST_ZERO;
		if (idx == int'(ADDR_JOG)) v = RST_JOG;
		if (idx == int'(ADDR_CTRL)) v = RST_CTRL;
		if (idx == int'(ADDR_A3_CODE)) v = RST_A3_CODE;
		if (idx >= int'(ADDR_TIME0) && idx < int'(ADDR_SCURVE0)) v = RST_TIME;
		if (idx >= int'(ADDR_SCURVE0) && idx < int'(ADDR_SCURVE0) + 3) begin
			v = RST_SCURVE;
		end
		if (idx == int'(ADDR_UPPER)) v = RST_UPPER;
		if (idx == int'(ADDR_FMAX)) v = RST_FMAX;
		if (idx == int'(ADDR_FMIN)) v = RST_FMIN;
		return v;
	endfunction
endpackage

/* design/srrs_ramp.sv */
// S-curve ramp generator that slews the output toward its target.
`timescale 1ns/1ns
module srrs_ramp import srrs_pkg::*; (
	input logic sys_clk,
	input logic rst_b,
	input logic tick,
	input logic [15:0] target,
	input logic [15:0] fmax,
	input logic [19:0] t_acc,
	input logic [19:0] t_dec,
	input logic [7:0] s_as,
	input logic [7:0] s_ae,
	input logic [7:0] s_ds,
	input logic [7:0] s_de,
	output logic [15:0] freq_q
);
	logic up, moving, step, end_now;
	logic [19:0] t;
	logic [7:0] s_st, s_en, s_cur, r_eff;
	logic [15:0] remain, freq_d;
	logic [27:0] den;
	logic [36:0] lhs;
	logic [23:0] rhs, add;
	logic [31:0] credit_q, credit_d;
	logic [7:0] r_q, r_d;
	logic end_q, end_d, up_q;

	// Direction picks the time pair half and the S-curve pair.
	assign up = target > freq_q;
	assign moving = target != freq_q;
	assign t = up ? t_acc : t_dec;
	assign s_st = up ? s_as : s_ds;
	assign s_en = up ? s_ae : s_de;
	assign s_cur = end_q ? s_en : s_st;
	assign r_eff = (s_cur == 8'h00) ? 8'h01 : r_q;
	assign remain = up ? target - freq_q : freq_q - target;
	// Rate is fmax * r / (t * s); r climbs over s ticks.
	assign den = 28'(t) * 28'((s_cur == 8'h00) ? 8'h01 : s_cur);
	assign add = 24'(fmax) * 24'(r_eff);
	assign step = credit_q >= 32'(den);
	// Enter the closing curve once the rate can just fall to zero.
	assign lhs = 37'(remain) * 37'(t) * 37'd2;
	assign rhs = 24'(fmax) * 24'(s_en);
	assign end_now = (s_en != 8'h00) && (lhs <= 37'(rhs));

	// Credit and rate profile for the next cycle.
	always_comb begin
		credit_d = credit_q + (tick ? 32'(add) : 32'h0000_0000);
		if (step) credit_d = credit_d - 32'(den);
		freq_d = freq_q;
		if (step) freq_d = up ? freq_q + 16'h0001 : freq_q - 16'h0001;
		r_d = r_q;
		end_d = end_q;
		if (tick && !end_q && end_now) begin
			r_d = s_en;
			end_d = 1'b1;
		end else if (tick && !end_q && r_q < s_st) begin
			r_d = r_q + 8'h01;
		end else if (tick && end_q && r_q > 8'h01) begin
			r_d = r_q - 8'h01;
		end
	end

	// A reversal or arrival restarts the profile from zero rate.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			freq_q <= 16'h0000;
			credit_q <= 32'h0000_0000;
			r_q <= 8'h00;
			end_q <= 1'b0;
			up_q <= 1'b0;
		end else if (!moving || up != up_q || t == 20'h0_0000) begin
			credit_q <= 32'h0000_0000;
			r_q <= 8'h00;
			end_q <= 1'b0;
			up_q <= up;
			// A new direction keeps its present output; only a zero ramp
			// time may jump, else a start would skip the whole ramp.
			freq_q <= (t == 20'h0_0000) ? target : freq_q;
		end else begin
			credit_q <= credit_d;
			r_q <= r_d;
			end_q <= end_d;
			freq_q <= freq_d;
		end
	end
endmodule

/* bench/srrs_ctrl_model.sv */
// Machine controller model that drives the contact and run inputs.
`timescale 1ns/1ns
module srrs_ctrl_model (
	input wire logic sys_clk,
	input wire logic [9:0] want_contacts,
	input wire logic want_fwd,
	input wire logic want_rev,
	output logic [9:0] contact_q,
	output logic run_fwd_q,
	output logic run_rev_q
);
	logic [3:0] stable_q;

	// Everything starts released so the block sees no run at power up.
	initial begin
		contact_q = 10'h000;
		run_fwd_q = 1'b0;
		run_rev_q = 1'b0;
		stable_q = 4'h0;
	end

	// Contacts follow at once; a new run command is held back until they have been
	// still for eight cycles, but the count is read before a change clears it, so a
	// run that arrives with new contacts passes in the same cycle as they do.
	always @(posedge sys_clk) begin
		contact_q <= want_contacts;
		if (contact_q != want_contacts) stable_q <= 4'h0;
		else if (stable_q != 4'hF) stable_q <= stable_q + 4'h1;
		run_fwd_q <= want_fwd && (run_fwd_q || stable_q >= 4'h8);
		run_rev_q <= want_rev && (run_rev_q || stable_q >= 4'h8);
	end
endmodule

/* bench/srrs_tb.sv */
// Self-checking bench for the speed reference selection and ramp block.
`timescale 1ns/1ns
module srrs_tb;
	import srrs_pkg::*;
	// A tick long enough that the steepest tested slope needs less than
	// one output step per cycle; zero-time changes settle in SETTLE.
	localparam int TICK = 400;
	localparam int SETTLE = 60;
	logic sys_clk, rst_b, op_jog_key_in, reg_wr, reg_rd;
	logic want_fwd, want_rev, run_fwd_in, run_rev_in;
	logic running_q, reverse_q, remote_indicator_q;
	logic [9:0] want_contacts, contact_in;
	logic [15:0] an1, an2, an3, reg_wdata, reg_rdata_q, out_freq_q, v, e;
	logic [5:0] reg_addr;
	logic [15:0] preset [16];
	logic [7:0] code [7];
	int error_cnt = 0;
	int checks = 0;
	int cycles = 0;
	int seed = 79604;
	int t;

	srrs_top #(.N_CONTACTS(10), .TICK_CYCLES(TICK)) uut (
		.sys_clk(sys_clk), .rst_b(rst_b), .contact_in(contact_in),
		.run_fwd_in(run_fwd_in), .run_rev_in(run_rev_in),
		.op_jog_key_in(op_jog_key_in), .analog_input_first(an1),
		.analog_input_second(an2), .analog_input_third(an3),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.out_freq_q(out_freq_q), .running_q(running_q),
		.reverse_q(reverse_q), .remote_indicator_q(remote_indicator_q)
	);

	srrs_ctrl_model partner (
		.sys_clk(sys_clk), .want_contacts(want_contacts),
		.want_fwd(want_fwd), .want_rev(want_rev), .contact_q(contact_in),
		.run_fwd_q(run_fwd_in), .run_rev_q(run_rev_in)
	);

	// Free-running 250 MHz system clock.
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// A hung ramp must not stall the run forever.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 70000) begin
			error_cnt = error_cnt + 1;
			test_done();
		end
	end

	// Reset values of the stored settings, by word address.
	function automatic logic [15:0] exp_rst(input int a);
		if (a == 16) return 16'h0258;
		if (a == 27) return 16'h0006;
		if (a == 28) return 16'h001F;
		if (a == 44) return 16'h03E8;
		if (a == 47) return 16'h1770;
		if (a == 48) return 16'h0096;
		if (a >= 32 && a < 40) return 16'h0064;
		if (a >= 40 && a < 43) return 16'h0014;
		return 16'h0000;
	endfunction

	// Percent limit in tenths of a percent of the 60 Hz maximum.
	function automatic logic [15:0] pct(input int p);
		return 16'(p * 6000 / 1000);
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [5:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata_q;
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic go(input logic [9:0] c, input logic f, input logic r);
		@(posedge sys_clk);
		want_contacts <= c;
		want_fwd <= f;
		want_rev <= r;
	endtask

	task automatic test_done();
		$display("Checks %0d, errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		rst_b = 1'b0;
		op_jog_key_in = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 6'h00;
		reg_wdata = 16'h0000;
		want_contacts = 10'h000;
		want_fwd = 1'b0;
		want_rev = 1'b0;
		an1 = 16'(200 + ($unsigned($random(seed)) % 5800));
		an2 = 16'(200 + ($unsigned($random(seed)) % 5800));
		an3 = 16'(200 + ($unsigned($random(seed)) % 5800));
		code = '{FC_STEP1, FC_STEP2, FC_STEP3, FC_STEP4, FC_JOG, FC_TSEL1,
			FC_TSEL2};
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		// Every setting comes out of reset at its default; holes read 0.
		for (int a = 0; a < 51; a++) begin
			if (a == 30 || a == 31) continue;
			rd(6'(a));
			chk(v, exp_rst(a));
		end
		wr(6'h3F, 16'h5A5A);
		rd(6'h3F);
		chk(v, 16'h0000);
		chk({15'h0000, remote_indicator_q}, 16'h0001);
		// Reduced access hides presets five and up.
		wr(ADDR_CTRL, 16'h0004);
		wr(6'h04, 16'h1234);
		wr(6'h03, 16'h0111);
		rd(6'h04);
		chk(v, 16'h0000);
		rd(6'h03);
		chk(v, 16'h0111);
		wr(ADDR_CTRL, 16'h0002);
		rd(6'h04);
		chk(v, 16'h0000);
		// Contact functions, instant ramps, random presets.
		for (int i = 0; i < 7; i++) wr(ADDR_FCODE0 + 6'(i), {8'h00, code[i]});
		for (int i = 0; i < 8; i++) wr(ADDR_TIME0 + 6'(i), 16'h0000);
		for (int i = 0; i < 4; i++) wr(ADDR_SCURVE0 + 6'(i), 16'h0000);
		for (int i = 0; i < 16; i++) begin
			preset[i] = 16'(200 + ($unsigned($random(seed)) % 5800));
			wr(ADDR_SPEED0 + 6'(i), preset[i]);
		end
		for (int i = 0; i < 16; i++) begin
			go({6'h00, 4'(i)}, 1'b1, 1'b0);
			waitc(SETTLE);
			chk(out_freq_q, preset[i]);
		end
		// Analog sources for presets one to three.
		wr(ADDR_CTRL, 16'h0003);
		wr(ADDR_A3_CODE, 16'h0002);
		wr(ADDR_A2_CODE, 16'h0003);
		for (int i = 0; i < 3; i++) begin
			go({6'h00, 4'(i)}, 1'b1, 1'b0);
			waitc(SETTLE);
			e = (i == 0) ? an1 : (i == 1) ? an3 : an2;
			chk(out_freq_q, e);
		end
		wr(ADDR_CTRL, 16'h0002);
		// Jog beats all step selects and runs in reverse.
		go(10'h01F, 1'b0, 1'b1);
		waitc(SETTLE);
		chk(out_freq_q, 16'h0258);
		chk({15'h0000, reverse_q}, 16'h0001);
		wr(ADDR_MLOWER, 16'h00C8);
		waitc(SETTLE);
		chk(out_freq_q, 16'h0258);
		wr(ADDR_LOWER, 16'h00C8);
		waitc(SETTLE);
		chk(out_freq_q, pct(200));
		wr(ADDR_LOWER, 16'h0000);
		wr(ADDR_MLOWER, 16'h0000);
		// Upper clamp, then a zero reference against the lower limit.
		wr(ADDR_SPEED0 + 6'd5, 16'h1388);
		wr(ADDR_UPPER, 16'h01F4);
		go(10'h005, 1'b0, 1'b0);
		waitc(SETTLE);
		go(10'h005, 1'b1, 1'b0);
		waitc(SETTLE);
		chk(out_freq_q, pct(500));
		wr(ADDR_UPPER, 16'h03E8);
		wr(ADDR_SPEED0 + 6'd5, 16'h0000);
		wr(ADDR_LOWER, 16'h0064);
		waitc(SETTLE);
		chk(out_freq_q, pct(100));
		wr(ADDR_LOWER, 16'h0014);
		waitc(SETTLE);
		chk(out_freq_q, 16'h0000);
		chk({15'h0000, running_q}, 16'h0000);
		wr(ADDR_LOWER, 16'h0000);
		// Master lower limit lifts the master reference only.
		go(10'h000, 1'b1, 1'b0);
		wr(ADDR_MLOWER, 16'h03E8);
		waitc(SETTLE);
		chk(out_freq_q, pct(1000));
		wr(ADDR_MLOWER, 16'h0000);
		// Each time pair gives its own ramp to 30 Hz; pair one in 0.1 s.
		wr(ADDR_SPEED0, 16'h0BB8);
		for (int p = 0; p < 4; p++) begin
			go(10'h000, 1'b0, 1'b0);
			wr(ADDR_CTRL, (p == 0) ? 16'h0006 : 16'h0002);
			wr(ADDR_TIME0 + 6'(2 * p), (p == 0) ? 16'h0002 : 16'(10 * (p + 2)));
			waitc(SETTLE);
			t = 5 * (p + 2);
			go({3'b000, 2'(p), 5'b00000}, 1'b1, 1'b0);
			waitc((t - 2) * TICK);
			chk({15'h0000, out_freq_q > 0 && out_freq_q < 16'h0BB8},
				16'h0001);
			waitc(5 * TICK);
			chk(out_freq_q, 16'h0BB8);
		end
		// S-curves add half their time at each end of the ramp.
		go(10'h000, 1'b0, 1'b0);
		wr(ADDR_CTRL, 16'h0002);
		wr(ADDR_TIME0, 16'h0014);
		wr(ADDR_SCURVE0, 16'h000A);
		wr(ADDR_SCURVE0 + 6'd1, 16'h000A);
		wr(ADDR_SPEED0, 16'h1770);
		waitc(SETTLE);
		go(10'h000, 1'b1, 1'b0);
		waitc(25 * TICK);
		chk({15'h0000, out_freq_q < 16'h1770}, 16'h0001);
		waitc(10 * TICK);
		chk(out_freq_q, 16'h1770);
		// Local mode: the panel jog key alone starts and stops a jog.
		go(10'h000, 1'b0, 1'b0);
		wr(ADDR_CTRL, 16'h000A);
		@(posedge sys_clk);
		op_jog_key_in <= 1'b1;
		waitc(6 * TICK);
		chk(out_freq_q, 16'h0258);
		chk({15'h0000, remote_indicator_q}, 16'h0000);
		@(posedge sys_clk);
		op_jog_key_in <= 1'b0;
		waitc(SETTLE);
		chk(out_freq_q, 16'h0000);
		test_done();
	end
endmodule
